// ==== rtl/mdlink_pkg.sv ====
package mdlink_pkg;
  // Clock and line timing
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          LOW_BAUD        = 300;
  localparam int          BIT_CYC_LOW     = CLK_HZ / LOW_BAUD;
  localparam int          BIT_CNT_W       = 19;
  // Record layout and characters
  localparam int          REC_LEN         = 12;
  localparam logic [7:0]  CH_STX          = 8'h02;
  localparam logic [7:0]  CH_ETX          = 8'h03;
  localparam logic [7:0]  CH_ZERO         = 8'h30;
  localparam logic [7:0]  CH_MSG_PARAM    = 8'h33;
  localparam logic [7:0]  ERR_OK          = 8'h40;
  // Error byte bit positions
  localparam int          EB_RANGE        = 5;
  localparam int          EB_CODE         = 4;
  localparam int          EB_FORMAT       = 3;
  localparam int          EB_DATA         = 2;
  localparam int          EB_PARITY       = 1;
  // Setting ranges and codes
  localparam logic [5:0]  STATION_GLOBAL  = 6'h00;
  localparam logic [5:0]  STATION_MIN     = 6'h01;
  localparam logic [5:0]  STATION_MAX     = 6'h20;
  localparam logic [2:0]  RATE_MIN        = 3'h1;
  localparam logic [2:0]  RATE_MAX        = 3'h6;
  localparam logic [1:0]  FRAME_8N1       = 2'h1;
  localparam logic [1:0]  FRAME_7E1       = 2'h2;
  localparam logic [1:0]  FRAME_8N2       = 2'h3;
  localparam logic [6:0]  PARAM_PANEL_LOCK = 7'h62;
  localparam logic [6:0]  PARAM_MASTER_SCALE = 7'h14;
  localparam logic [6:0]  PARAM_FOLLOW_SCALE = 7'h15;
  localparam logic [3:0]  FMT_MAX_SCALED  = 4'h7;
  // Register offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_LIMIT       = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_APPLIED     = 8'h0C;
  // Field positions
  localparam int          F_STATION       = 0;
  localparam int          F_RATE          = 8;
  localparam int          F_FRAME         = 12;
  localparam int          F_MASK          = 16;
  localparam int          F_PTOP          = 24;
  localparam int          F_LMIN          = 0;
  localparam int          F_LMAX          = 16;
  localparam int          F_BUSY          = 8;
  localparam int          F_APARAM        = 16;
  localparam int          F_AFMT          = 24;
  localparam int          F_AVALID        = 31;
  // Reset values
  localparam logic [5:0]  RST_STATION     = 6'h01;
  localparam logic [2:0]  RST_RATE        = 3'h6;
  localparam logic [1:0]  RST_FRAME       = 2'h1;
  localparam logic [1:0]  RST_MASK        = 2'h0;
  localparam logic [6:0]  RST_PTOP        = 7'h63;
  localparam logic [13:0] RST_LMIN        = 14'h0000;
  localparam logic [13:0] RST_LMAX        = 14'h270F;
endpackage

// ==== rtl/serial_char_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module serial_char_port
  import mdlink_pkg::*;
(
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // Line setup
  input  wire logic [BIT_CNT_W-1:0] bit_cycles,
  input  wire logic [1:0]           framing,
  // Receive side
  input  wire logic                 rxd,
  output logic                      rx_valid,
  output logic [7:0]                rx_byte,
  output logic                      rx_parity_err,
  // Transmit side
  input  wire logic                 tx_start,
  input  wire logic [7:0]           tx_byte,
  output logic                      tx_busy,
  output logic                      txd
);
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_BUSY = 2'b10} rx_state_t;

  rx_state_t              rx_st_ff;
  logic [BIT_CNT_W-1:0]   rx_cnt_ff;
  logic [3:0]             rx_ix_ff;
  logic [7:0]             rx_sh_ff;
  logic                   rx_par_ff;
  logic [BIT_CNT_W-1:0]   tx_cnt_ff;
  logic [3:0]             tx_left_ff;
  logic [10:0]            tx_sh_ff;

  wire logic              seven    = (framing == FRAME_7E1);
  wire logic              two_stop = (framing == FRAME_8N2);
  wire logic              rx_tick  = (rx_cnt_ff == '0);
  wire logic              in_data  = (rx_ix_ff >= 4'h1) && (rx_ix_ff <= (seven ? 4'h7 : 4'h8));
  wire logic [7:0]        rx_word  = seven ? {1'b0, rx_sh_ff[7:1]} : rx_sh_ff;
  wire logic [10:0]       tx_frame = seven    ? {2'b11, ^tx_byte[6:0], tx_byte[6:0], 1'b0} :
                                     two_stop ? {1'b1, 1'b1, tx_byte, 1'b0} :
                                                {2'b11, tx_byte, 1'b0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_ff      <= R_IDLE;
      rx_cnt_ff     <= '0;
      rx_ix_ff      <= 4'h0;
      rx_sh_ff      <= 8'h00;
      rx_par_ff     <= 1'b0;
      rx_valid      <= 1'b0;
      rx_byte       <= 8'h00;
      rx_parity_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      unique case (rx_st_ff)
        R_IDLE: begin
          if (!rxd) begin
            rx_st_ff  <= R_BUSY;
            rx_cnt_ff <= bit_cycles >> 1;
            rx_ix_ff  <= 4'h0;
            rx_par_ff <= 1'b0;
          end
        end
        R_BUSY: begin
          if (!rx_tick) begin
            rx_cnt_ff <= rx_cnt_ff - 1'b1;
          end else begin
            rx_cnt_ff <= bit_cycles - 1'b1;
            rx_ix_ff  <= rx_ix_ff + 1'b1;
            if (rx_ix_ff == 4'h0 && rxd) begin
              rx_st_ff <= R_IDLE;
            end else if (in_data) begin
              rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
              rx_par_ff <= rx_par_ff ^ rxd;
            end else if (rx_ix_ff == 4'h8) begin
              rx_par_ff <= rx_par_ff ^ rxd;
            end else if (rx_ix_ff == 4'h9) begin
              rx_st_ff      <= R_IDLE;
              rx_valid      <= 1'b1;
              rx_byte       <= rx_word;
              rx_parity_err <= seven & rx_par_ff;
            end
          end
        end
      endcase
    end
  end

  // Frame goes out LSB first; idle line is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt_ff  <= '0;
      tx_left_ff <= 4'h0;
      tx_sh_ff   <= 11'h7FF;
      tx_busy    <= 1'b0;
      txd        <= 1'b1;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_sh_ff   <= tx_frame;
        tx_left_ff <= two_stop ? 4'hB : 4'hA;
        tx_cnt_ff  <= '0;
        tx_busy    <= 1'b1;
      end
    end else if (tx_cnt_ff != '0) begin
      tx_cnt_ff <= tx_cnt_ff - 1'b1;
    end else if (tx_left_ff == 4'h0) begin
      tx_busy <= 1'b0;
      txd     <= 1'b1;
    end else begin
      txd        <= tx_sh_ff[0];
      tx_sh_ff   <= {1'b1, tx_sh_ff[10:1]};
      tx_left_ff <= tx_left_ff - 1'b1;
      tx_cnt_ff  <= bit_cycles - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/multidrop_ascii_param_link.sv ====
`timescale 1ns/10ps
`default_nettype none
module multidrop_ascii_param_link
  import mdlink_pkg::*;
#(
  parameter int BIT_CYCLES_LOW = BIT_CYC_LOW
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Serial link
  input  wire logic                  rxd,
  output logic                       txd,
  output logic                       tx_enable,
  // Parameter write to drive
  output logic                       param_write_strobe,
  output logic [6:0]                 param_number,
  output logic [13:0]                param_value,
  output logic [3:0]                 param_format,
  // Remote control permissions: fast_halt, run, ramp_halt, master_follower, setpoint_sel
  output logic [4:0]                 remote_allow
);
  typedef enum logic [3:0] {
    S_HUNT  = 4'b0001,
    S_RECV  = 4'b0010,
    S_EVAL  = 4'b0100,
    S_REPLY = 4'b1000
  } link_state_t;

  function automatic logic is_digit(input logic [7:0] ch);
    return (ch >= CH_ZERO) && (ch <= 8'h39);
  endfunction

  function automatic logic [3:0] digit_val(input logic [7:0] ch);
    return 4'(ch - CH_ZERO);
  endfunction

  function automatic logic [6:0] two_digits(input logic [7:0] t, input logic [7:0] u);
    return 7'(digit_val(t) * 7'd10 + digit_val(u));
  endfunction

  function automatic logic [7:0] ascii_digit(input logic [3:0] d);
    return CH_ZERO + {4'h0, d};
  endfunction

  // Configuration and status registers
  logic [5:0]    station_number_setting_ff;
  logic [2:0]    line_rate_select_ff;
  logic [1:0]    char_framing_select_ff;
  logic [1:0]    remote_control_mask_ff;
  logic [6:0]    param_top_ff;
  logic [13:0]   limit_min_ff;
  logic [13:0]   limit_max_ff;
  logic [7:0]    link_error_monitor_ff;
  logic          applied_valid_ff;
  // Bus data phase
  logic          wr_pend_ff;
  logic [7:0]    wr_ofs_ff;
  // Record engine
  link_state_t   st_ff;
  logic [7:0]    rec_ff [0:REC_LEN-1];
  logic [3:0]    ix_ff;
  logic          par_err_ff;
  logic          early_etx_ff;
  logic [7:0]    err_ff;
  logic          tx_start_ff;
  logic [7:0]    tx_byte_ff;

  // UART hookup
  wire logic                 rx_valid;
  wire logic [7:0]           rx_byte;
  wire logic                 rx_parity_err;
  wire logic                 tx_busy;
  wire logic [BIT_CNT_W-1:0] bit_cycles =
    BIT_CNT_W'(BIT_CYCLES_LOW >> (line_rate_select_ff - RATE_MIN));

  serial_char_port u_port (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .bit_cycles    (bit_cycles),
    .framing       (char_framing_select_ff),
    .rxd           (rxd),
    .rx_valid      (rx_valid),
    .rx_byte       (rx_byte),
    .rx_parity_err (rx_parity_err),
    .tx_start      (tx_start_ff),
    .tx_byte       (tx_byte_ff),
    .tx_busy       (tx_busy),
    .txd           (txd)
  );

  // Address phase decode
  wire logic        addr_take  = hsel && htrans[1] && hready;
  wire logic [7:0]  addr_ofs   = haddr[7:0];
  wire logic        applied_set;
  wire logic [31:0] ctrl_word  = {1'b0, param_top_ff, 6'h00, remote_control_mask_ff, 2'h0,
                                  char_framing_select_ff, 1'b0, line_rate_select_ff, 2'h0,
                                  station_number_setting_ff};
  wire logic [31:0] limit_word = {2'h0, limit_max_ff, 2'h0, limit_min_ff};
  wire logic [31:0] stat_word  = {23'h0, (st_ff != S_HUNT), link_error_monitor_ff};
  wire logic [31:0] appl_word  = {applied_valid_ff, 3'h0, param_format, 1'b0, param_number,
                                  2'h0, param_value};
  wire logic [31:0] rd_word    = (addr_ofs == OFS_CTRL)    ? ctrl_word  :
                                 (addr_ofs == OFS_LIMIT)   ? limit_word :
                                 (addr_ofs == OFS_STATUS)  ? stat_word  :
                                 (addr_ofs == OFS_APPLIED) ? appl_word  : 32'h0000_0000;

  // Write data fields
  wire logic [5:0]  w_station = hwdata[F_STATION +: 6];
  wire logic [2:0]  w_rate    = hwdata[F_RATE +: 3];
  wire logic [1:0]  w_frame   = hwdata[F_FRAME +: 2];
  wire logic        wr_ctrl   = wr_pend_ff && (wr_ofs_ff == OFS_CTRL);
  wire logic        wr_limit  = wr_pend_ff && (wr_ofs_ff == OFS_LIMIT);
  wire logic        wr_appl   = wr_pend_ff && (wr_ofs_ff == OFS_APPLIED);
  wire logic        st_ok     = (w_station >= STATION_MIN) && (w_station <= STATION_MAX);
  wire logic        rate_ok   = (w_rate >= RATE_MIN) && (w_rate <= RATE_MAX);
  wire logic        frame_ok  = (w_frame != 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 8'h00;
    end else begin
      wr_pend_ff <= addr_take && hwrite;
      wr_ofs_ff  <= addr_ofs;
      if (addr_take && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      station_number_setting_ff <= RST_STATION;
      line_rate_select_ff       <= RST_RATE;
      char_framing_select_ff    <= RST_FRAME;
      remote_control_mask_ff    <= RST_MASK;
      param_top_ff              <= RST_PTOP;
      limit_min_ff              <= RST_LMIN;
      limit_max_ff              <= RST_LMAX;
    end else if (wr_ctrl) begin
      if (st_ok) begin
        station_number_setting_ff <= w_station;
      end
      if (rate_ok) begin
        line_rate_select_ff <= w_rate;
      end
      if (frame_ok) begin
        char_framing_select_ff <= w_frame;
      end
      remote_control_mask_ff <= hwdata[F_MASK +: 2];
      param_top_ff           <= hwdata[F_PTOP +: 7];
    end else if (wr_limit) begin
      limit_min_ff <= hwdata[F_LMIN +: 14];
      limit_max_ff <= hwdata[F_LMAX +: 14];
    end
  end

  // Mask bit order: fast_halt, run, ramp_halt, master_follower, setpoint_sel
  wire logic [4:0] allow_dec = (remote_control_mask_ff == 2'h0) ? 5'h10 :
                               (remote_control_mask_ff == 2'h1) ? 5'h1C :
                               (remote_control_mask_ff == 2'h2) ? 5'h13 : 5'h1F;

  // Record field decode
  wire logic       addr_digits = is_digit(rec_ff[1]) && is_digit(rec_ff[2]);
  wire logic [6:0] rec_station = two_digits(rec_ff[1], rec_ff[2]);
  wire logic       is_global   = addr_digits && (rec_station == 7'(STATION_GLOBAL));
  wire logic       is_mine     = addr_digits &&
                                 (rec_station == 7'(station_number_setting_ff));
  wire logic       pnum_digits = is_digit(rec_ff[4]) && is_digit(rec_ff[5]);
  wire logic [6:0] pnum        = two_digits(rec_ff[4], rec_ff[5]);
  wire logic       data_digits = is_digit(rec_ff[6]) && is_digit(rec_ff[7]) &&
                                 is_digit(rec_ff[8]) && is_digit(rec_ff[9]);
  wire logic [13:0] pvalue     = 14'(digit_val(rec_ff[6]) * 14'd1000 +
                                 digit_val(rec_ff[7]) * 14'd100 +
                                 digit_val(rec_ff[8]) * 14'd10 +
                                 digit_val(rec_ff[9]));
  wire logic       fmt_digit   = is_digit(rec_ff[10]);
  wire logic [3:0] fmt         = digit_val(rec_ff[10]);
  wire logic       scaled      = (pnum == PARAM_MASTER_SCALE) || (pnum == PARAM_FOLLOW_SCALE);
  wire logic       fmt_bad     = !fmt_digit || (fmt > FMT_MAX_SCALED) ||
                                 (!scaled && fmt != 4'h0);
  wire logic       pnum_bad    = !pnum_digits || (pnum == PARAM_PANEL_LOCK) ||
                                 (pnum > param_top_ff);
  wire logic       e_format    = early_etx_ff || (rec_ff[11] != CH_ETX) ||
                                 (rec_ff[3] != CH_MSG_PARAM);
  wire logic       e_code      = pnum_bad || fmt_bad;
  wire logic       e_data      = !data_digits;
  wire logic       e_range     = data_digits &&
                                 ((pvalue < limit_min_ff) || (pvalue > limit_max_ff));
  wire logic [7:0] err_byte    = ERR_OK | (8'(e_range) << EB_RANGE) | (8'(e_code) << EB_CODE) |
                                 (8'(e_format) << EB_FORMAT) | (8'(e_data) << EB_DATA) |
                                 (8'(par_err_ff) << EB_PARITY);
  wire logic       accept      = (st_ff == S_EVAL) && (is_mine || is_global);
  assign applied_set = accept && (err_byte == ERR_OK);

  // Reply character selection
  wire logic [3:0] st_tens = 4'(station_number_setting_ff / 6'd10);
  wire logic [3:0] st_ones = 4'(station_number_setting_ff % 6'd10);
  wire logic [7:0] reply_ch = (ix_ff == 4'h0)  ? CH_STX :
                              (ix_ff == 4'h1)  ? ascii_digit(st_tens) :
                              (ix_ff == 4'h2)  ? ascii_digit(st_ones) :
                              (ix_ff == 4'h3)  ? err_ff :
                              (ix_ff == 4'hB)  ? CH_ETX : rec_ff[ix_ff];
  wire logic       rx_stx   = rx_valid && (rx_byte == CH_STX);
  wire logic       last_ch  = (ix_ff == 4'(REC_LEN - 1));
  wire logic       can_send = !tx_start_ff && !tx_busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff        <= S_HUNT;
      ix_ff        <= 4'h0;
      par_err_ff   <= 1'b0;
      early_etx_ff <= 1'b0;
      err_ff       <= ERR_OK;
      tx_start_ff  <= 1'b0;
      tx_byte_ff   <= 8'h00;
      tx_enable    <= 1'b0;
    end else begin
      tx_start_ff <= 1'b0;
      unique case (st_ff)
        S_HUNT: begin
          if (rx_stx) begin
            st_ff        <= S_RECV;
            ix_ff        <= 4'h1;
            par_err_ff   <= rx_parity_err;
            early_etx_ff <= 1'b0;
          end
        end
        S_RECV: begin
          if (rx_stx) begin
            ix_ff      <= 4'h1;
            par_err_ff <= rx_parity_err;
          end else if (rx_valid) begin
            ix_ff      <= ix_ff + 1'b1;
            par_err_ff <= par_err_ff | rx_parity_err;
            if (last_ch || rx_byte == CH_ETX) begin
              st_ff        <= S_EVAL;
              early_etx_ff <= !last_ch;
            end
          end
        end
        S_EVAL: begin
          err_ff <= err_byte;
          ix_ff  <= 4'h0;
          if (is_mine && !is_global) begin
            st_ff     <= S_REPLY;
            tx_enable <= 1'b1;
          end else begin
            st_ff <= S_HUNT;
          end
        end
        S_REPLY: begin
          if (can_send) begin
            if (ix_ff == 4'(REC_LEN)) begin
              st_ff     <= S_HUNT;
              tx_enable <= 1'b0;
            end else begin
              tx_start_ff <= 1'b1;
              tx_byte_ff  <= reply_ch;
              ix_ff       <= ix_ff + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Record store: a short record leaves stale tail slots, flagged as format error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < REC_LEN; i++) begin
        rec_ff[i] <= 8'h00;
      end
    end else if (rx_stx && (st_ff == S_HUNT || st_ff == S_RECV)) begin
      rec_ff[0] <= CH_STX;
    end else if (rx_valid && st_ff == S_RECV) begin
      rec_ff[ix_ff] <= rx_byte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_error_monitor_ff <= 8'h00;
      applied_valid_ff      <= 1'b0;
      param_write_strobe    <= 1'b0;
      param_number          <= 7'h00;
      param_value           <= 14'h0000;
      param_format          <= 4'h0;
      remote_allow          <= 5'h10;
    end else begin
      remote_allow       <= allow_dec;
      param_write_strobe <= applied_set;
      if (accept) begin
        link_error_monitor_ff <= err_byte & ~ERR_OK;
      end
      if (applied_set) begin
        param_number <= pnum;
        param_value  <= pvalue;
        param_format <= fmt;
      end
      // Set wins over a same-cycle clear
      if (applied_set) begin
        applied_valid_ff <= 1'b1;
      end else if (wr_appl && hwdata[F_AVALID]) begin
        applied_valid_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/link_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_props
  import mdlink_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        txd,
  input wire logic        tx_enable,
  input wire logic        param_write_strobe,
  input wire logic [6:0]  param_number,
  input wire logic [13:0] param_value,
  input wire logic [3:0]  param_format,
  input wire logic [4:0]  remote_allow
);
  wire logic stb = param_write_strobe;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence start_bit;
    ##[1:4] !txd;
  endsequence
  a_idle_high: assert property (!tx_enable |-> txd) else $error("txd idle");
  a_reply_start: assert property ($rose(tx_enable) |-> start_bit)
    else $error("no start");
  a_strobe_once: assert property (stb |=> !stb) else $error("long strobe");
  a_lock_kept: assert property (stb |-> param_number != PARAM_PANEL_LOCK)
    else $error("lock");
  a_fmt_max: assert property (stb |-> param_format <= FMT_MAX_SCALED)
    else $error("fmt");
  a_fmt_plain: assert property (stb && param_number != PARAM_MASTER_SCALE
    && param_number != PARAM_FOLLOW_SCALE |-> param_format == 4'h0) else $error("fmt zero");
  a_value_max: assert property (stb |-> param_value <= 14'h270F) else $error("value");
  a_mask_code: assert property (remote_allow inside {5'h10, 5'h1C, 5'h13, 5'h1F})
    else $error("mask");
endmodule
bind multidrop_ascii_param_link link_props u_props (.hclk, .hresetn, .txd, .tx_enable,
  .param_write_strobe, .param_number, .param_value, .param_format, .remote_allow);
`default_nettype wire

// ==== test/host_link_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_link_model #(
  parameter int BCYC = 8
) (
  input  wire logic hclk,
  input  wire logic txd,
  output logic      rxd
);
  // Line setup, changed by the bench while the link is quiet
  int bcyc    = BCYC;
  bit seven   = 1'b0;
  bit bad_par = 1'b0;
  initial rxd = 1'b1;
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = seven ? {1'b1, ^c[6:0] ^ bad_par, c[6:0], 1'b0} : {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (bcyc) @(posedge hclk);
    end
  endtask
  task automatic send_rec(input logic [95:0] r);
    for (int i = 0; i < 12; i++) send_char(r[95-8*i -: 8]);
  endtask
  task automatic get_reply(output logic [95:0] r, output bit ok);
    int n;
    r = 96'h0;
    ok = 1'b0;
    for (int i = 0; i < 12; i++) begin
      for (n = 0; txd !== 1'b0 && n < 3000; n++) @(posedge hclk);
      if (n == 3000) return;
      repeat (bcyc + bcyc / 2) @(posedge hclk);
      for (int b = 0; b < 8; b++) begin
        r[88-8*i+b] = txd;
        repeat (bcyc) @(posedge hclk);
      end
      // Eighth bit is parity in seven-bit framing
      if (seven) r[95-8*i] = 1'b0;
    end
    ok = 1'b1;
    repeat (bcyc) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ==== test/multidrop_ascii_param_link_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module multidrop_ascii_param_link_bench;
  import mdlink_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, rxd, txd, tx_enable, stb;
  logic [6:0]  num;
  logic [13:0] val;
  logic [3:0]  fmt;
  logic [4:0]  allow;
  int          mismatches = 0, samples_checked = 0;
  always #4 hclk = ~hclk;
  multidrop_ascii_param_link #(.BIT_CYCLES_LOW(256)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rxd(rxd), .txd(txd), .tx_enable(tx_enable), .param_write_strobe(stb),
    .param_number(num), .param_value(val), .param_format(fmt), .remote_allow(allow));
  host_link_model host (.hclk(hclk), .txd(txd), .rxd(rxd));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rdy();
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    mismatches++;
    give_verdict();
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic xfer(input logic [95:0] rec, input logic [95:0] exp, input bit ans);
    logic [95:0] rep;
    bit          ok;
    fork
      host.send_rec(rec);
      host.get_reply(rep, ok);
    join
    `CHK("reply seen", ans, ok)
    if (ans) `CHK("reply", exp, rep)
    if (ans && !ok) give_verdict();
  endtask
  task automatic t_regs();
    logic [4:0] tbl [4] = '{5'h10, 5'h1C, 5'h13, 5'h1F};
    bus(1'b0, OFS_CTRL, 0);
    `CHK("ctrl", 32'h63001601, rd)
    bus(1'b0, 8'h10, 0);
    `CHK("unmapped", 32'h0, rd)
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_CTRL, 32'h63001621 | {14'h0, 2'(m), 16'h0});
      bus(1'b0, OFS_CTRL, 0);
      `CHK("allow", tbl[m], allow)
      `CHK("station", 6'h01, rd[5:0])
    end
    bus(1'b1, OFS_CTRL, 32'h63001604);
    $display("regs done");
  endtask
  task automatic t_write();
    host.send_char(8'h41);
    xfer("\0020431605230\003", "\00204@1605230\003", 1'b1);
    `CHK("number", 7'h10, num)
    `CHK("value", 14'h020B, val)
    xfer("\0020432009992\003", "\00204@2009992\003", 1'b1);
    `CHK("format", 4'h2, fmt)
    $display("write done");
  endtask
  task automatic t_errors();
    xfer("\0020439800010\003", "\00204P9800010\003", 1'b1);
    bus(1'b0, OFS_STATUS, 0);
    `CHK("status", 8'h10, rd[7:0])
    xfer("\002043160A230\003", "\00204D160A230\003", 1'b1);
    xfer("\0020421605230\003", "\00204H1605230\003", 1'b1);
    bus(1'b1, OFS_LIMIT, 32'h00640000);
    xfer("\0020431605230\003", "\00204`1605230\003", 1'b1);
    bus(1'b0, OFS_APPLIED, 0);
    `CHK("applied", 32'h821403E7, rd)
    $display("errors done");
  endtask
  task automatic t_silent();
    xfer("\0020031700010\003", 96'h0, 1'b0);
    `CHK("global", 7'h11, num)
    xfer("\0020531700020\003", 96'h0, 1'b0);
    `CHK("other", 14'h0001, val)
    $display("silent done");
  endtask
  // Seven-bit even parity at 4800 baud, then eight bits with two stops
  task automatic t_frame();
    bus(1'b1, OFS_CTRL, 32'h63002504);
    host.seven = 1'b1;
    host.bcyc = 16;
    xfer("\0020431600500\003", "\00204@1600500\003", 1'b1);
    `CHK("value", 14'h0032, val)
    host.bad_par = 1'b1;
    xfer("\0020431600600\003", "\00204B1600600\003", 1'b1);
    bus(1'b0, OFS_STATUS, 0);
    `CHK("parity", 8'h02, rd[7:0])
    `CHK("kept", 14'h0032, val)
    host.bad_par = 1'b0;
    host.seven = 1'b0;
    host.bcyc = 8;
    bus(1'b1, OFS_CTRL, 32'h63003604);
    xfer("\0020431600600\003", "\00204@1600600\003", 1'b1);
    `CHK("value", 14'h003C, val)
    $display("frame done");
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_write();
    t_errors();
    t_silent();
    t_frame();
    give_verdict();
  end
endmodule
`default_nettype wire
